/* logic/iapri_core.v */
`timescale 1ns/1ps
`include "iapri_defines.vh"

module iapri_core (
	input wire clk_i,
	input wire rst_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [11:0] paddr_i,
	input wire [31:0] pwdata_i,
	output wire [31:0] prdata_o,
	output wire pready_o,
	output wire pslverr_o,
	input wire [1:0] range_sel_i,
	input wire boot_mode_i,
	input wire seq_busy_i,
	output wire seq_start_o,
	output wire seq_erase_o,
	output wire seq_program_o,
	output wire [1:0] seq_cmd_o,
	output wire [1:0] seq_region_o,
	output wire [15:0] seq_addr_o,
	output wire [7:0] seq_data_o,
	output wire [1:0] table_region_o,
	output wire iap_open_o,
	output wire cpu_hold_o
);

	// byte address to register index, zero when misaligned
	function [7:0] reg_index;
		input [11:0] addr;
		begin
			if (addr[1:0] != 2'b00) begin
				reg_index = 8'h00;
			end else begin
				reg_index = addr[9:2];
			end
		end
	endfunction

	// index belongs to the map
	function mapped;
		input [7:0] idx;
		begin
			mapped = (idx >= `IAPRI_IDX_KEY) && (idx <= `IAPRI_IDX_STS);
		end
	endfunction

	// write strobe for one register index
	function strobe;
		input write;
		input [7:0] at;
		input [7:0] want;
		begin
			strobe = write && (at == want);
		end
	endfunction

	// software visible bytes and status
	reg [7:0] key_reg;
	reg [7:0] adl_reg;
	reg [7:0] adh_reg;
	reg [7:0] rgn_reg;
	reg [7:0] dat_reg;
	reg [7:0] ctl_reg;
	reg refused_reg;
	reg [31:0] prdata_reg;
	reg [31:0] prdata_next;
	reg start_reg;
	reg erase_reg;
	reg program_reg;
	reg [1:0] cmd_reg;
	reg [1:0] srgn_reg;
	reg [15:0] saddr_reg;
	reg [7:0] sdata_reg;
	reg [1:0] tbl_reg;

	// bus decode and command nets
	wire [7:0] idx;
	wire hit;
	wire setup;
	wire access;
	wire wr;
	wire key_wr;
	wire ctl_wr;
	wire sts_wr;
	wire cmd_req;
	wire cmd_start;
	wire cmd_refuse;
	wire open;
	wire write_ok;
	wire [15:0] target;
	wire [7:0] cmd_bits;
	wire [1:0] tbl_next;

	// ****************************************************
	// apb decode
	// ****************************************************
	assign idx = reg_index(paddr_i);
	assign hit = mapped(idx) && (paddr_i[11:10] == 2'b00) &&
		(paddr_i[1:0] == 2'b00);
	assign setup = psel_i && !penable_i;
	assign access = psel_i && penable_i;
	assign wr = access && pwrite_i && hit;
	assign pready_o = 1'b1; // zero wait states
	assign pslverr_o = access && !hit;
	assign prdata_o = prdata_reg;

	assign key_wr = strobe(wr, idx, `IAPRI_IDX_KEY);
	assign ctl_wr = strobe(wr, idx, `IAPRI_IDX_CTL);
	assign sts_wr = strobe(wr, idx, `IAPRI_IDX_STS);

	assign target = {adh_reg, adl_reg};

	// erase and program bits, self-clearing on launch
	assign cmd_bits = (8'h01 << `IAPRI_BIT_ERASE) |
		(8'h01 << `IAPRI_BIT_PROG);

	// ****************************************************
	// command acceptance
	// ****************************************************
	// a control write with erase or program set asks for work
	assign cmd_req = ctl_wr && (pwdata_i[`IAPRI_BIT_ERASE] ||
		pwdata_i[`IAPRI_BIT_PROG]);
	assign cmd_start = cmd_req && open && write_ok && !seq_busy_i &&
		!start_reg;
	assign cmd_refuse = cmd_req && !cmd_start;

	// unlock window and its timeout
	iapri_unlock_timer u_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.key_wr_i(key_wr),
		.key_val_i(pwdata_i[7:0]),
		.cmd_start_i(cmd_start),
		.open_o(open)
	);

	// region and range permission
	iapri_region_guard u_guard (
		.region_i(rgn_reg),
		.addr_i(target),
		.range_sel_i(range_sel_i),
		.boot_mode_i(boot_mode_i || ctl_reg[`IAPRI_BIT_BOOT]),
		.write_ok_o(write_ok),
		.table_region_o(tbl_next)
	);

	// ****************************************************
	// software registers
	// ****************************************************
	// key kept for read back
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			key_reg <= `IAPRI_RST_BYTE;
		end else if (key_wr) begin
			key_reg <= pwdata_i[7:0];
		end
	end

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			adl_reg <= `IAPRI_RST_BYTE;
		end else if (strobe(wr, idx, `IAPRI_IDX_ADL)) begin
			adl_reg <= pwdata_i[7:0];
		end
	end

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			adh_reg <= `IAPRI_RST_BYTE;
		end else if (strobe(wr, idx, `IAPRI_IDX_ADH)) begin
			adh_reg <= pwdata_i[7:0];
		end
	end

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rgn_reg <= `IAPRI_RST_BYTE;
		end else if (strobe(wr, idx, `IAPRI_IDX_REG)) begin
			rgn_reg <= pwdata_i[7:0];
		end
	end

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			dat_reg <= `IAPRI_RST_BYTE;
		end else if (strobe(wr, idx, `IAPRI_IDX_DAT)) begin
			dat_reg <= pwdata_i[7:0];
		end
	end

	// control byte; command bits are consumed on launch
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctl_reg <= `IAPRI_RST_BYTE;
		end else if (ctl_wr && cmd_start) begin
			ctl_reg <= pwdata_i[7:0] & `IAPRI_CTL_MASK & ~cmd_bits;
		end else if (ctl_wr) begin
			ctl_reg <= pwdata_i[7:0] & `IAPRI_CTL_MASK;
		end
	end

	// refused flag; a new refusal wins over the clear
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			refused_reg <= 1'b0;
		end else if (cmd_refuse) begin
			refused_reg <= 1'b1;
		end else if (sts_wr && pwdata_i[`IAPRI_STS_REFUSED]) begin
			refused_reg <= 1'b0;
		end
	end

	// ****************************************************
	// sequencer request latch
	// ****************************************************
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			start_reg <= 1'b0;
			erase_reg <= 1'b0;
			program_reg <= 1'b0;
			cmd_reg <= 2'b00;
			srgn_reg <= 2'b00;
			saddr_reg <= 16'h0000;
			sdata_reg <= `IAPRI_RST_BYTE;
		end else begin
			start_reg <= cmd_start;
			if (cmd_start) begin
				erase_reg <= pwdata_i[`IAPRI_BIT_ERASE];
				program_reg <= pwdata_i[`IAPRI_BIT_PROG];
				cmd_reg <= pwdata_i[1:0];
				srgn_reg <= rgn_reg[1:0];
				saddr_reg <= target;
				sdata_reg <= dat_reg;
			end
		end
	end

	// sequencer outputs straight from the latch
	assign seq_start_o = start_reg;
	assign seq_erase_o = erase_reg;
	assign seq_program_o = program_reg;
	assign seq_cmd_o = cmd_reg;
	assign seq_region_o = srgn_reg;
	assign seq_addr_o = saddr_reg;
	assign seq_data_o = sdata_reg;
	assign iap_open_o = open;

	// table read target, held in a flop
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			tbl_reg <= 2'b00;
		end else begin
			tbl_reg <= tbl_next;
		end
	end

	assign table_region_o = tbl_reg;

	// hold the cpu during the operation
	assign cpu_hold_o = start_reg || seq_busy_i;

	// ****************************************************
	// read data, captured in the setup cycle
	// ****************************************************
	always @* begin
		prdata_next = 32'h0000_0000;
		case (idx)
		`IAPRI_IDX_KEY: prdata_next[7:0] = key_reg;
		`IAPRI_IDX_ADL: prdata_next[7:0] = adl_reg;
		`IAPRI_IDX_ADH: prdata_next[7:0] = adh_reg;
		`IAPRI_IDX_REG: prdata_next[7:0] = rgn_reg;
		`IAPRI_IDX_DAT: prdata_next[7:0] = dat_reg;
		`IAPRI_IDX_CTL: prdata_next[7:0] = ctl_reg;
		`IAPRI_IDX_STS: begin
			prdata_next[`IAPRI_STS_OPEN] = open;
			prdata_next[`IAPRI_STS_BUSY] = cpu_hold_o;
			prdata_next[`IAPRI_STS_REFUSED] = refused_reg;
		end
		default: prdata_next = 32'h0000_0000;
		endcase
		if (!hit) begin
			prdata_next = 32'h0000_0000;
		end
	end

	// read data register, loaded only on a read setup
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			prdata_reg <= 32'h0000_0000;
		end else if (setup && !pwrite_i) begin
			prdata_reg <= prdata_next;
		end
	end

endmodule

/* logic/iapri_defines.vh */
`ifndef IAPRI_DEFINES_VH
`define IAPRI_DEFINES_VH

// ****************************************************
// register indices; byte address is four times these
// ****************************************************
`define IAPRI_IDX_KEY 8'hf1
`define IAPRI_IDX_ADL 8'hf2
`define IAPRI_IDX_ADH 8'hf3
`define IAPRI_IDX_REG 8'hf4
`define IAPRI_IDX_DAT 8'hf5
`define IAPRI_IDX_CTL 8'hf6
`define IAPRI_IDX_STS 8'hf7

// ****************************************************
// reset values and field positions
// ****************************************************
`define IAPRI_RST_BYTE 8'h00
`define IAPRI_CTL_MASK 8'hb3
`define IAPRI_BIT_BOOT 7
`define IAPRI_BIT_ERASE 5
`define IAPRI_BIT_PROG 4
`define IAPRI_STS_OPEN 0
`define IAPRI_STS_BUSY 1
`define IAPRI_STS_REFUSED 2

// ****************************************************
// key, region codes and range option
// ****************************************************
`define IAPRI_KEY_MIN 8'h40
`define IAPRI_RGN_CODE 8'h00
`define IAPRI_RGN_UID 8'h01
`define IAPRI_RGN_EEP 8'h02
`define IAPRI_RGN_BOOT 8'h03
`define IAPRI_RANGE_NONE 2'b00
`define IAPRI_RANGE_1K 2'b01
`define IAPRI_RANGE_2K 2'b10
`define IAPRI_RANGE_ALL 2'b11
`define IAPRI_BASE_1K 16'hfc00
`define IAPRI_BASE_2K 16'hf800

`endif

/* logic/iapri_unlock_timer.v */
`timescale 1ns/1ps
`include "iapri_defines.vh"

module iapri_unlock_timer (
	input wire clk_i,
	input wire rst_i,
	input wire key_wr_i,
	input wire [7:0] key_val_i,
	input wire cmd_start_i,
	output wire open_o
);

	reg open_reg;
	reg [7:0] cnt_reg;
	reg [7:0] len_reg;

	// ****************************************************
	// unlock window and timeout
	// ****************************************************
	assign open_o = open_reg;

	// key write opens or closes, counter runs down
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			open_reg <= 1'b0;
			cnt_reg <= `IAPRI_RST_BYTE;
			len_reg <= `IAPRI_RST_BYTE;
		end else if (key_wr_i) begin
			open_reg <= (key_val_i >= `IAPRI_KEY_MIN);
			cnt_reg <= key_val_i;
			len_reg <= key_val_i;
		end else if (open_reg && cmd_start_i) begin
			cnt_reg <= len_reg; // fresh n clocks
		end else if (open_reg) begin
			if (cnt_reg <= 8'h01) begin
				open_reg <= 1'b0;
				cnt_reg <= `IAPRI_RST_BYTE;
			end else begin
				cnt_reg <= cnt_reg - 8'h01;
			end
		end
	end

endmodule

/* logic/iapri_region_guard.v */
`timescale 1ns/1ps
`include "iapri_defines.vh"

module iapri_region_guard (
	input wire [7:0] region_i,
	input wire [15:0] addr_i,
	input wire [1:0] range_sel_i,
	input wire boot_mode_i,
	output wire write_ok_o,
	output wire [1:0] table_region_o
);

	// true for the four defined region codes
	function known_code;
		input [7:0] code;
		begin
			known_code = (code[7:2] == 6'h00);
		end
	endfunction

	reg app_ok;

	// ****************************************************
	// application flash range check
	// ****************************************************
	// range option gate
	always @* begin
		case (range_sel_i)
		`IAPRI_RANGE_NONE: app_ok = 1'b0;
		`IAPRI_RANGE_1K: app_ok = (addr_i >= `IAPRI_BASE_1K);
		`IAPRI_RANGE_2K: app_ok = (addr_i >= `IAPRI_BASE_2K);
		`IAPRI_RANGE_ALL: app_ok = 1'b1;
		default: app_ok = 1'b0;
		endcase
		if (boot_mode_i) begin
			app_ok = 1'b1; // bootloader may reach all of it
		end
	end

	// ****************************************************
	// write permission per region
	// ****************************************************
	// code flash programmable inside the range option or in boot mode; eeprom programmable
	assign write_ok_o = known_code(region_i) &&
		((region_i == `IAPRI_RGN_CODE && app_ok) ||
		(region_i == `IAPRI_RGN_EEP));

	// table read target; reserved codes fall back to code
	assign table_region_o = region_i[1:0] & {2{known_code(region_i)}};

endmodule

/* sim/iapri_core_sva.sv */
`timescale 1ns/1ps
module iapri_core_sva (
	input wire clk_i,
	input wire rst_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [11:0] paddr_i,
	input wire [31:0] pwdata_i,
	input wire pslverr_o,
	input wire seq_busy_i,
	input wire seq_start_o,
	input wire [1:0] seq_region_o,
	input wire iap_open_o,
	input wire cpu_hold_o
);
	// ****
	// key, launch and bus checks
	// ****
	wire acc = psel_i && penable_i;
	wire map_ok = paddr_i[1:0] == 2'h0 && paddr_i[11:2] >= 10'h0f1 &&
		paddr_i[11:2] <= 10'h0f7;
	// write access to the key register
	sequence s_key;
		acc && pwrite_i && paddr_i == 12'h3c4;
	endsequence
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	a_key_opens: assert property (
		s_key ##0 pwdata_i[7:0] >= 8'h40 |=> iap_open_o)
		else $error("key did not open");
	a_key_closes: assert property (
		s_key ##0 pwdata_i[7:0] < 8'h40 |=> !iap_open_o)
		else $error("small key left open");
	a_start_open: assert property (
		seq_start_o |-> $past(iap_open_o))
		else $error("launch while closed");
	a_start_idle: assert property (
		seq_start_o |-> !$past(seq_busy_i))
		else $error("launch while busy");
	a_hold_src: assert property (
		cpu_hold_o == (seq_start_o || seq_busy_i))
		else $error("hold mismatch");
	a_region_ok: assert property (
		seq_start_o |-> !seq_region_o[0])
		else $error("launch into read-only region");
	a_start_pulse: assert property (
		$rose(seq_start_o) |=> !seq_start_o)
		else $error("start longer than one cycle");
	a_unmapped_err: assert property (acc && !map_ok |-> pslverr_o)
		else $error("no error on unmapped");
	a_mapped_ok: assert property (acc && map_ok |-> !pslverr_o)
		else $error("error on mapped");
endmodule

bind iapri_core iapri_core_sva i_sva (.clk_i, .rst_i, .psel_i, .penable_i,
	.pwrite_i, .paddr_i, .pwdata_i, .pslverr_o, .seq_busy_i, .seq_start_o,
	.seq_region_o, .iap_open_o, .cpu_hold_o);

/* sim/iapri_core_tb.sv */
`timescale 1ns/1ps
module iapri_core_tb;
	reg clk_i = 1'h0;
	reg rst_i = 1'h1;
	reg psel_i = 1'h0;
	reg penable_i = 1'h0;
	reg pwrite_i = 1'h0;
	reg [11:0] paddr_i = 12'h000;
	reg [31:0] pwdata_i = 32'h0000_0000;
	reg [1:0] range_sel_i = 2'h3;
	reg boot_mode_i = 1'h0;
	reg seq_busy_i = 1'h0;
	wire [31:0] prdata_o;
	wire pready_o, pslverr_o, seq_start_o, seq_erase_o, seq_program_o;
	wire [1:0] seq_cmd_o, seq_region_o, table_region_o;
	wire [15:0] seq_addr_o;
	wire [7:0] seq_data_o;
	wire iap_open_o, cpu_hold_o;
	integer error_cnt = 0;
	integer compares = 0;
	integer i;
	reg [31:0] rd;
	reg err, st;
	iapri_core i_dut (.clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
		.paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .range_sel_i,
		.boot_mode_i, .seq_busy_i, .seq_start_o, .seq_erase_o, .seq_program_o,
		.seq_cmd_o, .seq_region_o, .seq_addr_o, .seq_data_o, .table_region_o,
		.iap_open_o, .cpu_hold_o);
	// ****
	// clock, compare and bus tasks
	// ****
	initial forever #4 clk_i = ~clk_i;
	function [11:0] ba(input [7:0] x);
		ba = {2'h0, x, 2'h0};
	endfunction
	task chk(input [31:0] got, input [31:0] exp);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				error_cnt = error_cnt + 1;
				$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	// one transfer; start is sampled 1 ns after the access edge
	task apb(input w, input [11:0] a, input [7:0] d);
		begin
			psel_i <= 1'h1;
			pwrite_i <= w;
			paddr_i <= a;
			pwdata_i <= {24'h00_0000, d};
			@(posedge clk_i);
			penable_i <= 1'h1;
			@(posedge clk_i);
			while (pready_o !== 1'h1) @(posedge clk_i);
			rd = prdata_o;
			err = pslverr_o;
			psel_i <= 1'h0;
			penable_i <= 1'h0;
			#1 st = seq_start_o;
			@(posedge clk_i);
		end
	endtask
	task go(input [7:0] k, input [7:0] r, input [15:0] a, input [7:0] c);
		begin
			apb(1'h1, 12'h3c4, k);
			apb(1'h1, 12'h3d0, r);
			apb(1'h1, 12'h3cc, a[15:8]);
			apb(1'h1, 12'h3c8, a[7:0]);
			apb(1'h1, 12'h3d4, 8'ha5);
			apb(1'h1, 12'h3d8, c);
		end
	endtask
	task rng(input [1:0] rs, input bm, input [15:0] a, input e);
		begin
			range_sel_i <= rs;
			boot_mode_i <= bm;
			go(8'hff, 8'h00, a, 8'h20);
			chk(st, e);
		end
	endtask
	task t_regs;
		begin
			for (i = 0; i < 7; i = i + 1) begin
				apb(1'h0, ba(8'hf1 + i), 8'h00);
				chk(rd, 32'h0000_0000);
			end
			for (i = 1; i < 5; i = i + 1)
				apb(1'h1, ba(8'hf1 + i), 8'h50 + i);
			for (i = 1; i < 5; i = i + 1) begin
				apb(1'h0, ba(8'hf1 + i), 8'h00);
				chk(rd, 8'h50 + i);
			end
			apb(1'h0, 12'h3e0, 8'h00);
			chk({err, rd[30:0]}, 32'h8000_0000);
		end
	endtask
	task t_key;
		begin
			apb(1'h1, 12'h3c4, 8'h3f);
			chk(iap_open_o, 1'h0);
			apb(1'h1, 12'h3c4, 8'h40);
			chk(iap_open_o, 1'h1);
			repeat (50) @(posedge clk_i);
			chk(iap_open_o, 1'h1);
			repeat (20) @(posedge clk_i);
			chk(iap_open_o, 1'h0);
		end
	endtask
	task t_launch;
		begin
			// sector erased before it is written
			for (i = 0; i < 3; i = i + 2) begin
				go(8'hff, i, 16'h1234, 8'h20);
				chk({st, seq_erase_o, seq_program_o}, 3'h6);
			end
			for (i = 0; i < 5; i = i + 1) begin
				go(8'hff, i, 16'h1234, 8'h11);
				chk(table_region_o, i < 4 ? i : 0);
				chk(st, i == 0 || i == 2);
				if (st === 1'h1) begin
					chk({seq_region_o, seq_addr_o}, {i[1:0], 16'h1234});
					chk({seq_cmd_o, seq_data_o}, 10'h1a5);
				end
			end
			go(8'hff, 8'h02, 16'h0200, 8'h20);
			chk({st, seq_erase_o, seq_program_o}, 3'h6);
		end
	endtask
	task t_guard;
		begin
			rng(2'h0, 1'h0, 16'hffff, 1'h0);
			rng(2'h1, 1'h0, 16'hfbff, 1'h0);
			rng(2'h1, 1'h0, 16'hfc00, 1'h1);
			rng(2'h2, 1'h0, 16'hf7ff, 1'h0);
			rng(2'h2, 1'h0, 16'hf800, 1'h1);
			// control bit7 bypass set by an earlier write
			apb(1'h1, 12'h3d8, 8'h80);
			go(8'hff, 8'h00, 16'h0000, 8'ha0);
			chk(st, 1'h1);
			apb(1'h1, 12'h3d8, 8'h00);
			rng(2'h0, 1'h1, 16'h0000, 1'h1);
			// boot region refused even in boot mode
			go(8'hff, 8'h03, 16'h0000, 8'h20);
			chk(st, 1'h0);
			// closed window refusal, flag cleared first
			apb(1'h1, 12'h3dc, 8'h04);
			apb(1'h0, 12'h3dc, 8'h00);
			chk(rd[2], 1'h0);
			go(8'h00, 8'h00, 16'h1234, 8'h10);
			chk(st, 1'h0);
			apb(1'h0, 12'h3dc, 8'h00);
			chk(rd[2], 1'h1);
			seq_busy_i <= 1'h1;
			go(8'hff, 8'h00, 16'h1234, 8'h10);
			chk({st, cpu_hold_o}, 2'h1);
			seq_busy_i <= 1'h0;
		end
	endtask
	task wrap_up;
		begin
			$display("errors=%0d compares=%0d", error_cnt, compares);
			if (error_cnt == 0 && compares > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	initial begin
		#100000;
		error_cnt = error_cnt + 1;
		wrap_up;
	end
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		t_regs;
		t_key;
		t_launch;
		t_guard;
		wrap_up;
	end
endmodule
